/* core/tbd_top.sv */
// Time base and decrementer: register-number decode, read answers and the
// down-counter exception request in front of the counter module.
// Assumes the core issues at most one request per cycle, on the same clock,
// and that TICK is a one-cycle enable made in the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module tbd_top (
  input  wire logic                           CLOCK,
  input  wire logic                           ARST_N,
  input  wire logic                           TICK,
  input  wire logic                           MOVE_TO,
  input  wire logic                           MOVE_FROM,
  input  wire logic                           READ_TICK_COUNTER,
  input  wire logic                           SUPERVISOR,
  input  wire logic [tbd_pkg::TBD_NUM_W-1:0]  SPECIAL_REGISTER_NUMBER,
  input  wire logic [tbd_pkg::TBD_HALF_W-1:0] WRITE_DATA,
  input  wire logic                           EXC_TAKEN,
  output logic      [tbd_pkg::TBD_HALF_W-1:0] READ_DATA,
  output logic                                ANSWER_VALID,
  output tbd_pkg::tbd_ans_t                   ANSWER,
  output logic                                DOWN_COUNTER_EXC_REQ
);
  import tbd_pkg::*;

  tbd_ctr_if ctr ();

  logic [TBD_HALF_W-1:0] next_read_data;
  tbd_ans_t              next_answer;
  logic                  wr_lower;
  logic                  wr_upper;
  logic                  wr_down;
  logic                  any_request;
  logic                  msb_prev;
  logic                  msb_rise;

  // ==========================================================================
  // Counter module
  // ==========================================================================
  assign ctr.tick     = TICK;
  assign ctr.wr_lower = wr_lower;
  assign ctr.wr_upper = wr_upper;
  assign ctr.wr_down  = wr_down;
  assign ctr.wdata    = WRITE_DATA;

  tbd_counter counter (
    .clk   (CLOCK),
    .rst_n (ARST_N),
    .bus   (ctr.ctr)
  );

  // ==========================================================================
  // Request decode
  // ==========================================================================
  // Move-to has priority over move-from, which has priority over the
  // dedicated read; the core never raises two at once, so the order only
  // keeps the decode defined.
  assign any_request = MOVE_TO | MOVE_FROM | READ_TICK_COUNTER;

  always_comb begin
    wr_lower       = 1'b0;
    wr_upper       = 1'b0;
    wr_down        = 1'b0;
    next_read_data = TBD_HALF_ZERO;
    next_answer    = TBD_ANS_OK;
    if (MOVE_TO) begin
      unique case (SPECIAL_REGISTER_NUMBER)
        TBD_NUM_LOWER_WRITE: begin
          if (SUPERVISOR) begin
            wr_lower = 1'b1;
          end else begin
            next_answer = TBD_ANS_PRIV;
          end
        end
        TBD_NUM_UPPER_WRITE: begin
          if (SUPERVISOR) begin
            wr_upper = 1'b1;
          end else begin
            next_answer = TBD_ANS_PRIV;
          end
        end
        TBD_NUM_DOWN_COUNTER: begin
          if (SUPERVISOR) begin
            wr_down = 1'b1;
          end else begin
            next_answer = TBD_ANS_PRIV;
          end
        end
        default: begin
          next_answer = TBD_ANS_INVALID;
        end
      endcase
    end else if (MOVE_FROM) begin
      unique case (SPECIAL_REGISTER_NUMBER)
        TBD_NUM_DOWN_COUNTER: begin
          if (SUPERVISOR) begin
            next_read_data = ctr.down_counter;
          end else begin
            next_answer = TBD_ANS_PRIV;
          end
        end
        default: begin
          // Tick counter halves and legacy clock halves are not readable here.
          next_answer = TBD_ANS_INVALID;
        end
      endcase
    end else if (READ_TICK_COUNTER) begin
      unique case (SPECIAL_REGISTER_NUMBER)
        TBD_NUM_LOWER_READ: begin
          next_read_data = ctr.tick_counter[31:0];
        end
        TBD_NUM_UPPER_READ: begin
          next_read_data = ctr.tick_counter[63:32];
        end
        default: begin
          next_answer = TBD_ANS_INVALID;
        end
      endcase
    end
  end

  // ==========================================================================
  // Answer registers
  // ==========================================================================
  // Read data is the value before any update in the request cycle, and is
  // zero whenever the answer is not OK, so no state leaks on a refusal.
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      READ_DATA    <= TBD_HALF_ZERO;
      ANSWER_VALID <= 1'b0;
      ANSWER       <= TBD_ANS_OK;
    end else begin
      READ_DATA    <= next_read_data;
      ANSWER_VALID <= any_request;
      ANSWER       <= next_answer;
    end
  end

  // ==========================================================================
  // Down counter exception request
  // ==========================================================================
  // The edge is taken on the counter value itself, so a software write that
  // sets the top bit raises the request just as a tick crossing zero does.
  assign msb_rise = ctr.down_counter[TBD_MSB] & ~msb_prev;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      msb_prev <= 1'b0;
    end else begin
      msb_prev <= ctr.down_counter[TBD_MSB];
    end
  end

  // A new edge in the cycle the core takes the exception wins over the clear.
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      DOWN_COUNTER_EXC_REQ <= 1'b0;
    end else if (msb_rise) begin
      DOWN_COUNTER_EXC_REQ <= 1'b1;
    end else if (EXC_TAKEN) begin
      DOWN_COUNTER_EXC_REQ <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  legacy_invalid_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (MOVE_TO && (SPECIAL_REGISTER_NUMBER == TBD_NUM_LEGACY_SEC_WR
                 || SPECIAL_REGISTER_NUMBER == TBD_NUM_LEGACY_NS_WR))
    || (!MOVE_TO && MOVE_FROM && (SPECIAL_REGISTER_NUMBER == TBD_NUM_LEGACY_SEC_RD
                                  || SPECIAL_REGISTER_NUMBER == TBD_NUM_LEGACY_NS_RD))
    |=> ANSWER_VALID && ANSWER == TBD_ANS_INVALID && READ_DATA == TBD_HALF_ZERO)
    else $error("legacy clock register number was accepted");

  legacy_nowrite_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    MOVE_TO && SPECIAL_REGISTER_NUMBER == TBD_NUM_LEGACY_NS_WR && !TICK
    |=> ctr.tick_counter == $past(ctr.tick_counter)
        && ctr.down_counter == $past(ctr.down_counter))
    else $error("legacy clock write changed a counter");

  move_from_count_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    !MOVE_TO && MOVE_FROM && SPECIAL_REGISTER_NUMBER == TBD_NUM_LOWER_READ
    |=> ANSWER == TBD_ANS_INVALID)
    else $error("tick counter readable by move-from");

  dedicated_read_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    !MOVE_TO && !MOVE_FROM && READ_TICK_COUNTER
    && SPECIAL_REGISTER_NUMBER == TBD_NUM_UPPER_READ
    |=> ANSWER_VALID && ANSWER == TBD_ANS_OK
        && READ_DATA == $past(ctr.tick_counter[63:32]))
    else $error("dedicated read returned wrong upper half");

  priv_read_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    !MOVE_TO && MOVE_FROM && SPECIAL_REGISTER_NUMBER == TBD_NUM_DOWN_COUNTER
    |=> ANSWER == (($past(SUPERVISOR)) ? TBD_ANS_OK : TBD_ANS_PRIV)
        && READ_DATA == (($past(SUPERVISOR)) ? $past(ctr.down_counter) : TBD_HALF_ZERO))
    else $error("down counter read privilege not enforced");

  exc_raise_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    ctr.down_counter[TBD_MSB] && !msb_prev |=> DOWN_COUNTER_EXC_REQ)
    else $error("exception request missed a top bit rise");

  exc_hold_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    DOWN_COUNTER_EXC_REQ && !EXC_TAKEN |=> DOWN_COUNTER_EXC_REQ)
    else $error("exception request dropped before taken");

  exc_cause_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    $rose(DOWN_COUNTER_EXC_REQ) |-> $past(ctr.down_counter[TBD_MSB]) && !$past(msb_prev))
    else $error("exception request rose without a down counter cause");

  tick_write_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    MOVE_TO && SUPERVISOR && SPECIAL_REGISTER_NUMBER == TBD_NUM_DOWN_COUNTER && TICK
    |=> ctr.down_counter == $past(WRITE_DATA))
    else $error("down counter write lost to a tick");

endmodule
`default_nettype wire

/* include/tbd_pkg.sv */
// Constants shared by the tick counter and down counter design files.
// Assumes the core presents one special-register request per cycle.
package tbd_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int TBD_COUNT_W = 64;
  localparam int TBD_HALF_W  = 32;
  localparam int TBD_NUM_W   = 10;

  // ==========================================================================
  // Register numbers
  // ==========================================================================
  localparam logic [9:0] TBD_NUM_DOWN_COUNTER  = 10'h016;
  localparam logic [9:0] TBD_NUM_LOWER_WRITE   = 10'h11C;
  localparam logic [9:0] TBD_NUM_UPPER_WRITE   = 10'h11D;
  localparam logic [9:0] TBD_NUM_LOWER_READ    = 10'h10C;
  localparam logic [9:0] TBD_NUM_UPPER_READ    = 10'h10D;
  localparam logic [9:0] TBD_NUM_LEGACY_SEC_RD = 10'h004;
  localparam logic [9:0] TBD_NUM_LEGACY_NS_RD  = 10'h005;
  localparam logic [9:0] TBD_NUM_LEGACY_SEC_WR = 10'h014;
  localparam logic [9:0] TBD_NUM_LEGACY_NS_WR  = 10'h015;

  // ==========================================================================
  // Reset values and special values
  // ==========================================================================
  localparam logic [63:0] TBD_COUNT_RESET = 64'h0000_0000_0000_0000;
  localparam logic [31:0] TBD_DOWN_RESET  = 32'h0000_0000;
  localparam logic [31:0] TBD_HALF_ONES   = 32'hFFFF_FFFF;
  localparam logic [31:0] TBD_HALF_ZERO   = 32'h0000_0000;
  localparam logic [63:0] TBD_COUNT_ONE   = 64'h0000_0000_0000_0001;
  localparam logic [31:0] TBD_DOWN_ONE    = 32'h0000_0001;
  localparam int          TBD_MSB         = 31;

  // ==========================================================================
  // Answer codes
  // ==========================================================================
  typedef enum logic [1:0] {
    TBD_ANS_OK      = 2'b00,
    TBD_ANS_INVALID = 2'b01,
    TBD_ANS_PRIV    = 2'b10
  } tbd_ans_t;

endpackage

/* include/tbd_ctr_if.sv */
// Interface between request decode and the counter module.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface tbd_ctr_if;
  import tbd_pkg::*;
  logic                   tick;
  logic                   wr_lower;
  logic                   wr_upper;
  logic                   wr_down;
  logic [TBD_HALF_W-1:0]  wdata;
  logic [TBD_COUNT_W-1:0] tick_counter;
  logic [TBD_HALF_W-1:0]  down_counter;

  modport ctl (
    output tick,
    output wr_lower,
    output wr_upper,
    output wr_down,
    output wdata,
    input  tick_counter,
    input  down_counter
  );
  modport ctr (
    input  tick,
    input  wr_lower,
    input  wr_upper,
    input  wr_down,
    input  wdata,
    output tick_counter,
    output down_counter
  );
endinterface
`default_nettype wire

/* core/tbd_counter.sv */
// The 64-bit tick counter and the 32-bit down counter.
// Assumes at most one write strobe per cycle and a one-cycle tick enable.
`timescale 1ns/1ps
`default_nettype none
module tbd_counter (
  input wire logic clk,
  input wire logic rst_n,
  tbd_ctr_if.ctr   bus
);
  import tbd_pkg::*;

  logic any_count_write;
  assign any_count_write = bus.wr_lower | bus.wr_upper;

  // ==========================================================================
  // Tick counter
  // ==========================================================================
  // A write replaces one half and the other half holds, so that a tick in
  // the same cycle cannot carry into freshly written software data.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.tick_counter <= TBD_COUNT_RESET;
    end else if (bus.wr_lower) begin
      bus.tick_counter[31:0] <= bus.wdata;
    end else if (bus.wr_upper) begin
      bus.tick_counter[63:32] <= bus.wdata;
    end else if (bus.tick) begin
      bus.tick_counter <= bus.tick_counter + TBD_COUNT_ONE;
    end
  end

  // ==========================================================================
  // Down counter
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.down_counter <= TBD_DOWN_RESET;
    end else if (bus.wr_down) begin
      bus.down_counter <= bus.wdata;
    end else if (bus.tick) begin
      bus.down_counter <= bus.down_counter - TBD_DOWN_ONE;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  count_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    bus.tick && !any_count_write |=> bus.tick_counter == $past(bus.tick_counter) + TBD_COUNT_ONE)
    else $error("tick counter did not step on a tick");

  half_carry_a: assert property (@(posedge clk) disable iff (!rst_n)
    bus.tick && !any_count_write && bus.tick_counter[31:0] == TBD_HALF_ONES
    |=> bus.tick_counter[31:0] == TBD_HALF_ZERO
        && bus.tick_counter[63:32] == $past(bus.tick_counter[63:32]) + TBD_DOWN_ONE)
    else $error("lower half overflow did not carry into upper half");

  full_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
    bus.tick && !any_count_write && (&bus.tick_counter) |=> bus.tick_counter == TBD_COUNT_RESET)
    else $error("tick counter did not wrap through all 64 bits");

  down_rate_a: assert property (@(posedge clk) disable iff (!rst_n)
    bus.tick && !bus.wr_down |=> bus.down_counter == $past(bus.down_counter) - TBD_DOWN_ONE)
    else $error("down counter did not step with the tick counter");

  down_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
    bus.tick && !bus.wr_down && bus.down_counter == TBD_HALF_ZERO
    |=> bus.down_counter == TBD_HALF_ONES)
    else $error("down counter did not wrap through all 32 bits");

  write_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    bus.wr_lower |=> bus.tick_counter[31:0] == $past(bus.wdata)
                     && bus.tick_counter[63:32] == $past(bus.tick_counter[63:32]))
    else $error("lower half write lost to a tick");

endmodule
`default_nettype wire

/* verif/tbd_core_model.sv */
// Behavioural model of the processor core issuing special-register requests.
// Assumes the block answers on the edge that takes a request, one cycle after it is driven.
`timescale 1ns/1ps
`default_nettype none
module tbd_core_model (
  input  wire logic                           clk,
  output logic                                move_to,
  output logic                                move_from,
  output logic                                read_tick,
  output logic                                supervisor,
  output logic      [tbd_pkg::TBD_NUM_W-1:0]  num,
  output logic      [tbd_pkg::TBD_HALF_W-1:0] wdata,
  output logic                                exc_taken,
  input  wire logic [tbd_pkg::TBD_HALF_W-1:0] rdata,
  input  wire logic                           ans_valid,
  input  wire tbd_pkg::tbd_ans_t              ans
);
  import tbd_pkg::*;
  // ==========================================================================
  // Requests
  // ==========================================================================
  initial begin
    {move_to, move_from, read_tick, supervisor, exc_taken} = 5'h00;
    num   = 10'h3FF;
    wdata = 32'h0000_0000;
  end
  // Kind 0 is a move-to, 1 a move-from, 2 the dedicated tick counter read.
  task automatic request(input logic [1:0] kind, input logic [9:0] n, input logic sup,
                         input logic [31:0] d, output logic v, output tbd_ans_t a,
                         output logic [31:0] q);
    @(posedge clk);
    move_to    <= (kind == 2'h0);
    move_from  <= (kind == 2'h1);
    read_tick  <= (kind == 2'h2);
    supervisor <= sup;
    num        <= n;
    wdata      <= d;
    @(posedge clk);
    {move_to, move_from, read_tick} <= 3'h0;
    // Released lines change so that a late sample of them cannot pass.
    num   <= ~n;
    wdata <= ~d;
    #1;
    v = ans_valid;
    a = ans;
    q = rdata;
  endtask
  task automatic take_exception();
    @(posedge clk);
    exc_taken <= 1'b1;
    @(posedge clk);
    exc_taken <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* verif/time_base_and_decrementer_test.sv */
// Self-checking bench for the time base and down counter block.
// Assumes the core model in verif/ drives every register request.
`timescale 1ns/1ps
`default_nettype none
module time_base_and_decrementer_test;
  import tbd_pkg::*;
  localparam logic [1:0] K_TO = 2'h0, K_FROM = 2'h1, K_RD = 2'h2;
  logic clk, arst_n, tick, mt, mf, rt, sup, taken, vld, req;
  logic [9:0]  num;
  logic [31:0] wd, rd;
  tbd_ans_t    ans;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;

  tbd_top i_dut (.CLOCK(clk), .ARST_N(arst_n), .TICK(tick), .MOVE_TO(mt), .MOVE_FROM(mf),
    .READ_TICK_COUNTER(rt), .SUPERVISOR(sup), .SPECIAL_REGISTER_NUMBER(num),
    .WRITE_DATA(wd), .EXC_TAKEN(taken), .READ_DATA(rd), .ANSWER_VALID(vld),
    .ANSWER(ans), .DOWN_COUNTER_EXC_REQ(req));
  tbd_core_model i_core (.clk(clk), .move_to(mt), .move_from(mf), .read_tick(rt),
    .supervisor(sup), .num(num), .wdata(wd), .exc_taken(taken), .rdata(rd),
    .ans_valid(vld), .ans(ans));

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic access(input logic [1:0] k, input logic [9:0] n, input logic s,
                        input logic [31:0] d, input tbd_ans_t ea, input logic [31:0] eq,
                        input string what);
    logic v;
    tbd_ans_t a;
    logic [31:0] q;
    i_core.request(k, n, s, d, v, a, q);
    check({what, " valid"}, 32'h1, {31'h0, v});
    check({what, " answer"}, {30'h0, ea}, {30'h0, a});
    check({what, " data"}, eq, q);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
    end
    @(posedge clk);
    tick <= 1'b0;
  endtask
  // The request is registered, so a few edges are allowed for it to appear.
  task automatic wait_req(input string what);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 4 && !seen; i++) begin
      @(posedge clk);
      #1;
      seen = (req === 1'b1);
    end
    check(what, 32'h1, {31'h0, seen});
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic test_reset();
    access(K_RD, TBD_NUM_LOWER_READ, 1'b0, 0, TBD_ANS_OK, 0, "lower");
    access(K_RD, TBD_NUM_UPPER_READ, 1'b0, 0, TBD_ANS_OK, 0, "upper");
    access(K_FROM, TBD_NUM_DOWN_COUNTER, 1'b1, 0, TBD_ANS_OK, 0, "down");
    check("exc idle", 32'h0, {31'h0, req});
  endtask
  task automatic test_exception();
    ticks(1);
    wait_req("exc on tick wrap");
    repeat (5) @(posedge clk);
    #1;
    check("exc held", 32'h1, {31'h0, req});
    i_core.take_exception();
    #1;
    check("exc cleared", 32'h0, {31'h0, req});
  endtask
  task automatic test_carry();
    access(K_TO, TBD_NUM_LOWER_WRITE, 1'b1, 32'hFFFF_FFFE, TBD_ANS_OK, 0, "wr lo");
    access(K_TO, TBD_NUM_UPPER_WRITE, 1'b1, 32'h0000_0005, TBD_ANS_OK, 0, "wr hi");
    ticks(3);
    access(K_RD, TBD_NUM_LOWER_READ, 1'b0, 0, TBD_ANS_OK, 32'h1, "carry lo");
    access(K_RD, TBD_NUM_UPPER_READ, 1'b0, 0, TBD_ANS_OK, 32'h6, "carry hi");
    access(K_TO, TBD_NUM_UPPER_WRITE, 1'b1, 32'hFFFF_FFFF, TBD_ANS_OK, 0, "ones hi");
    access(K_TO, TBD_NUM_LOWER_WRITE, 1'b1, 32'hFFFF_FFFF, TBD_ANS_OK, 0, "ones lo");
    access(K_RD, TBD_NUM_UPPER_READ, 1'b0, 0, TBD_ANS_OK, 32'hFFFF_FFFF, "all hi");
    ticks(1);
    access(K_RD, TBD_NUM_LOWER_READ, 1'b0, 0, TBD_ANS_OK, 0, "wrap lo");
    access(K_RD, TBD_NUM_UPPER_READ, 1'b0, 0, TBD_ANS_OK, 0, "wrap hi");
  endtask
  task automatic test_down();
    access(K_TO, TBD_NUM_LOWER_WRITE, 1'b1, 0, TBD_ANS_OK, 0, "clr lo");
    access(K_TO, TBD_NUM_DOWN_COUNTER, 1'b1, 32'h5, TBD_ANS_OK, 0, "wr down");
    ticks(3);
    access(K_RD, TBD_NUM_LOWER_READ, 1'b0, 0, TBD_ANS_OK, 32'h3, "rate lo");
    access(K_FROM, TBD_NUM_DOWN_COUNTER, 1'b1, 0, TBD_ANS_OK, 32'h2, "rate dn");
    access(K_TO, TBD_NUM_DOWN_COUNTER, 1'b1, 32'h8000_0001, TBD_ANS_OK, 0, "msb wr");
    wait_req("exc on write");
    access(K_FROM, TBD_NUM_DOWN_COUNTER, 1'b1, 0, TBD_ANS_OK, 32'h8000_0001, "msb");
    i_core.take_exception();
  endtask
  task automatic test_refuse();
    logic [9:0] rd_num [2] = '{TBD_NUM_LEGACY_SEC_RD, TBD_NUM_LEGACY_NS_RD};
    logic [9:0] wr_num [2] = '{TBD_NUM_LEGACY_SEC_WR, TBD_NUM_LEGACY_NS_WR};
    access(K_TO, TBD_NUM_LOWER_WRITE, 1'b1, 32'h0000_0100, TBD_ANS_OK, 0, "pre lo");
    for (int i = 0; i < 2; i++) begin
      access(K_FROM, rd_num[i], 1'b1, 0, TBD_ANS_INVALID, 0, "legacy rd");
      access(K_TO, wr_num[i], 1'b1, 32'h1234_5678, TBD_ANS_INVALID, 0, "legacy wr");
    end
    access(K_RD, TBD_NUM_LEGACY_NS_RD, 1'b1, 0, TBD_ANS_INVALID, 0, "legacy tb");
    access(K_TO, TBD_NUM_LOWER_READ, 1'b1, 32'h5555, TBD_ANS_INVALID, 0, "wr rd");
    access(K_FROM, TBD_NUM_LOWER_READ, 1'b1, 0, TBD_ANS_INVALID, 0, "mf lo");
    access(K_FROM, TBD_NUM_DOWN_COUNTER, 1'b0, 0, TBD_ANS_PRIV, 0, "user dn");
    access(K_TO, TBD_NUM_LOWER_WRITE, 1'b0, 32'hDEAD_BEEF, TBD_ANS_PRIV, 0, "user wr");
    access(K_TO, TBD_NUM_UPPER_WRITE, 1'b0, 32'h77, TBD_ANS_PRIV, 0, "user hi");
    access(K_TO, TBD_NUM_DOWN_COUNTER, 1'b0, 32'h1, TBD_ANS_PRIV, 0, "user dwr");
    access(K_RD, TBD_NUM_LOWER_READ, 1'b0, 0, TBD_ANS_OK, 32'h0000_0100, "kept lo");
    access(K_RD, TBD_NUM_UPPER_READ, 1'b0, 0, TBD_ANS_OK, 0, "kept hi");
    access(K_FROM, TBD_NUM_DOWN_COUNTER, 1'b1, 0, TBD_ANS_OK, 32'h8000_0001, "kept");
  endtask
  task automatic test_write_wins();
    access(K_TO, TBD_NUM_LOWER_WRITE, 1'b1, 32'h0000_0040, TBD_ANS_OK, 0, "pre lo");
    access(K_TO, TBD_NUM_DOWN_COUNTER, 1'b1, 32'h0000_000A, TBD_ANS_OK, 0, "pre dn");
    fork
      ticks(1);
      access(K_TO, TBD_NUM_LOWER_WRITE, 1'b1, 32'h0000_0020, TBD_ANS_OK, 0, "race");
    join
    access(K_RD, TBD_NUM_LOWER_READ, 1'b0, 0, TBD_ANS_OK, 32'h20, "win lo");
    access(K_RD, TBD_NUM_UPPER_READ, 1'b0, 0, TBD_ANS_OK, 0, "win hi");
    access(K_FROM, TBD_NUM_DOWN_COUNTER, 1'b1, 0, TBD_ANS_OK, 32'h9, "win dn");
    // A down counter write beside a tick: the tick still steps the tick counter.
    fork
      ticks(1);
      access(K_TO, TBD_NUM_DOWN_COUNTER, 1'b1, 32'h30, TBD_ANS_OK, 0, "race dn");
    join
    // An upper half write beside a tick: the tick is lost on the tick counter only.
    fork
      ticks(1);
      access(K_TO, TBD_NUM_UPPER_WRITE, 1'b1, 32'h7, TBD_ANS_OK, 0, "race hi");
    join
    access(K_RD, TBD_NUM_LOWER_READ, 1'b0, 0, TBD_ANS_OK, 32'h21, "step lo");
    access(K_RD, TBD_NUM_UPPER_READ, 1'b0, 0, TBD_ANS_OK, 32'h7, "race hi rd");
    access(K_FROM, TBD_NUM_DOWN_COUNTER, 1'b1, 0, TBD_ANS_OK, 32'h2F, "race dn rd");
  endtask

  // ==========================================================================
  // Run control
  // ==========================================================================
  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      $display("Error timeout expected finish seen hang");
      print_verdict();
    end
  end
  initial begin
    arst_n = 1'b0;
    tick   = 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    test_reset();
    test_exception();
    test_carry();
    test_down();
    test_refuse();
    test_write_wins();
    print_verdict();
  end
endmodule
`default_nettype wire
